// ---- verilog/rrre_pkg.sv ----
package rrre_pkg;

    localparam int DATA_W     = 8;
    localparam int PC_W       = 15;
    localparam int FADDR_W    = 7;
    localparam int INT_EN_BIT = 7;
    localparam int RET_CYCLES = 2;
    localparam int ROT_CYCLES = 1;

    localparam logic [DATA_W-1:0]  DATA_RST = 8'h00;
    localparam logic [PC_W-1:0]    PC_RST   = 15'h0000;
    localparam logic [FADDR_W-1:0] FADDR_RST = 7'h00;

    typedef enum logic [2:0] {
        RRRE_OP_SOFT_RESET,
        RRRE_OP_RETURN_FROM_INTERRUPT,
        RRRE_OP_RETURN,
        RRRE_OP_RETURN_WITH_LITERAL,
        RRRE_OP_ROTATE_LEFT_CARRY,
        RRRE_OP_ROTATE_RIGHT_CARRY
    } rrre_op_e;

    typedef enum logic {
        RRRE_ST_IDLE,
        RRRE_ST_RET_LOAD
    } rrre_state_e;

endpackage

// ---- verilog/rrre_rot_if.sv ----
`timescale 1ns/1ns
interface rrre_rot_if;
    import rrre_pkg::*;

    logic [DATA_W-1:0] data;
    logic              carry_in;
    logic              left;
    logic [DATA_W-1:0] result;
    logic              carry_out;

    modport core (
        output data,
        output carry_in,
        output left,
        input  result,
        input  carry_out
    );

    modport rot (
        input  data,
        input  carry_in,
        input  left,
        output result,
        output carry_out
    );
endinterface

// ---- verilog/rrre_rotator.sv ----
`timescale 1ns/1ns
module rrre_rotator #(
    parameter int WIDTH = rrre_pkg::DATA_W
) (
    rrre_rot_if.rot rot
);
    import rrre_pkg::*;

    if (WIDTH != DATA_W) begin : g_width_check
        $error("rrre_rotator: width must match the data path");
    end

    ////////////////////////////////////////////////////////////////////////
    // Both rotations pass through carry, so the ring is WIDTH+1 bits long.
    always_comb begin
        if (rot.left) begin
            rot.result    = {rot.data[WIDTH-2:0], rot.carry_in};
            rot.carry_out = rot.data[WIDTH-1];
        end else begin
            rot.result    = {rot.carry_in, rot.data[WIDTH-1:1]};
            rot.carry_out = rot.data[0];
        end
    end
endmodule

// ---- verilog/rrre_exec.sv ----
// Contract
// - A software reset operation raises a full device reset request.
// - Return from interrupt pops the stack into the PC over 2 cycles.
// - Return from interrupt sets the global interrupt enable, no flags.
// - Plain return pops the stack into the PC in 2 cycles, no flags.
// - Return with literal writes its 8-bit literal into W, no flags.
// - Return with literal also loads the PC from the top of stack.
// - Rotate right moves bits down through carry, only carry changes.
// - Destination bit 0 writes W, destination bit 1 writes the file.
`timescale 1ns/1ns
module rrre_exec (
    input  wire logic                        clk,
    input  wire logic                        rstn,
    input  wire logic                        op_valid_i,
    input  wire rrre_pkg::rrre_op_e          op_i,
    input  wire logic [rrre_pkg::DATA_W-1:0] literal_i,
    input  wire logic [rrre_pkg::FADDR_W-1:0] faddr_i,
    input  wire logic                        dest_i,
    input  wire logic [rrre_pkg::DATA_W-1:0] f_rdata_i,
    input  wire logic                        carry_i,
    input  wire logic [rrre_pkg::PC_W-1:0]   top_of_stack_i,
    output logic                             busy_o,
    output logic                             done_o,
    output logic                             stack_pop_o,
    output logic                             pc_load_o,
    output logic [rrre_pkg::PC_W-1:0]        pc_value_o,
    output logic                             int_enable_set_o,
    output logic                             w_we_o,
    output logic [rrre_pkg::DATA_W-1:0]      w_data_o,
    output logic                             f_we_o,
    output logic [rrre_pkg::FADDR_W-1:0]     f_addr_o,
    output logic [rrre_pkg::DATA_W-1:0]      f_wdata_o,
    output logic                             carry_we_o,
    output logic                             carry_o,
    output logic                             soft_reset_req_o
);
    import rrre_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    rrre_rot_if rot_bus ();

    rrre_rotator #(
        .WIDTH (DATA_W)
    ) u_rot (
        .rot (rot_bus.rot)
    );

    assign rot_bus.data     = f_rdata_i;
    assign rot_bus.carry_in = carry_i;
    assign rot_bus.left     = (op_i == RRRE_OP_ROTATE_LEFT_CARRY);

    ////////////////////////////////////////////////////////////////////////
    rrre_state_e             state_ff, nxt_state;
    rrre_op_e                op_ff, nxt_op;
    logic [DATA_W-1:0]       lit_ff, nxt_lit;
    logic [PC_W-1:0]         ret_pc_ff, nxt_ret_pc;
    logic                    busy_ff, nxt_busy;
    logic                    done_ff, nxt_done;
    logic                    pop_ff, nxt_pop;
    logic                    pc_load_ff, nxt_pc_load;
    logic [PC_W-1:0]         pc_ff, nxt_pc;
    logic                    int_en_ff, nxt_int_en;
    logic                    w_we_ff, nxt_w_we;
    logic [DATA_W-1:0]       w_ff, nxt_w;
    logic                    f_we_ff, nxt_f_we;
    logic [FADDR_W-1:0]      f_addr_ff, nxt_f_addr;
    logic [DATA_W-1:0]       f_wdata_ff, nxt_f_wdata;
    logic                    c_we_ff, nxt_c_we;
    logic                    c_ff, nxt_c;
    logic                    rst_req_ff, nxt_rst_req;
    logic                    take;

    // Once a reset has been requested no further operation is taken, so
    // nothing can retire between the request and the device reset.
    assign take = op_valid_i && (state_ff == RRRE_ST_IDLE) && !rst_req_ff;

    function automatic logic is_return(input rrre_op_e op);
        return (op == RRRE_OP_RETURN_FROM_INTERRUPT) ||
               (op == RRRE_OP_RETURN) ||
               (op == RRRE_OP_RETURN_WITH_LITERAL);
    endfunction

    always_comb begin
        nxt_state   = state_ff;
        nxt_op      = op_ff;
        nxt_lit     = lit_ff;
        nxt_ret_pc  = ret_pc_ff;
        nxt_busy    = busy_ff;
        nxt_done    = 1'b0;
        nxt_pop     = 1'b0;
        nxt_pc_load = 1'b0;
        nxt_pc      = pc_ff;
        nxt_int_en  = 1'b0;
        nxt_w_we    = 1'b0;
        nxt_w       = w_ff;
        nxt_f_we    = 1'b0;
        nxt_f_addr  = f_addr_ff;
        nxt_f_wdata = f_wdata_ff;
        nxt_c_we    = 1'b0;
        nxt_c       = c_ff;
        nxt_rst_req = rst_req_ff;
        case (state_ff)
            RRRE_ST_IDLE: begin
                if (take && op_i == RRRE_OP_SOFT_RESET) begin
                    nxt_rst_req = 1'b1;
                    nxt_done    = 1'b1;
                end else if (take && is_return(op_i)) begin
                    // First cycle pops; the PC is loaded in the second.
                    nxt_state = RRRE_ST_RET_LOAD;
                    nxt_busy  = 1'b1;
                    nxt_pop   = 1'b1;
                    nxt_ret_pc = top_of_stack_i;
                    nxt_op    = op_i;
                    nxt_lit   = literal_i;
                end else if (take) begin
                    nxt_done = 1'b1;
                    nxt_c_we = 1'b1;
                    nxt_c    = rot_bus.carry_out;
                    if (dest_i) begin
                        nxt_f_we    = 1'b1;
                        nxt_f_addr  = faddr_i;
                        nxt_f_wdata = rot_bus.result;
                    end else begin
                        nxt_w_we = 1'b1;
                        nxt_w    = rot_bus.result;
                    end
                end
            end
            RRRE_ST_RET_LOAD: begin
                nxt_state   = RRRE_ST_IDLE;
                nxt_busy    = 1'b0;
                nxt_done    = 1'b1;
                nxt_pc_load = 1'b1;
                nxt_pc      = ret_pc_ff;
                if (op_ff == RRRE_OP_RETURN_FROM_INTERRUPT) begin
                    nxt_int_en = 1'b1;
                end
                if (op_ff == RRRE_OP_RETURN_WITH_LITERAL) begin
                    nxt_w_we = 1'b1;
                    nxt_w    = lit_ff;
                end
            end
            default: begin
                nxt_state = RRRE_ST_IDLE;
                nxt_busy  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff   <= RRRE_ST_IDLE;
            op_ff      <= RRRE_OP_RETURN;
            lit_ff     <= DATA_RST;
            ret_pc_ff  <= PC_RST;
            busy_ff    <= 1'b0;
            done_ff    <= 1'b0;
            pop_ff     <= 1'b0;
            pc_load_ff <= 1'b0;
            pc_ff      <= PC_RST;
            int_en_ff  <= 1'b0;
            w_we_ff    <= 1'b0;
            w_ff       <= DATA_RST;
            f_we_ff    <= 1'b0;
            f_addr_ff  <= FADDR_RST;
            f_wdata_ff <= DATA_RST;
            c_we_ff    <= 1'b0;
            c_ff       <= 1'b0;
            rst_req_ff <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            op_ff      <= nxt_op;
            lit_ff     <= nxt_lit;
            ret_pc_ff  <= nxt_ret_pc;
            busy_ff    <= nxt_busy;
            done_ff    <= nxt_done;
            pop_ff     <= nxt_pop;
            pc_load_ff <= nxt_pc_load;
            pc_ff      <= nxt_pc;
            int_en_ff  <= nxt_int_en;
            w_we_ff    <= nxt_w_we;
            w_ff       <= nxt_w;
            f_we_ff    <= nxt_f_we;
            f_addr_ff  <= nxt_f_addr;
            f_wdata_ff <= nxt_f_wdata;
            c_we_ff    <= nxt_c_we;
            c_ff       <= nxt_c;
            rst_req_ff <= nxt_rst_req;
        end
    end

    assign busy_o           = busy_ff;
    assign done_o           = done_ff;
    assign stack_pop_o      = pop_ff;
    assign pc_load_o        = pc_load_ff;
    assign pc_value_o       = pc_ff;
    assign int_enable_set_o = int_en_ff;
    assign w_we_o           = w_we_ff;
    assign w_data_o         = w_ff;
    assign f_we_o           = f_we_ff;
    assign f_addr_o         = f_addr_ff;
    assign f_wdata_o        = f_wdata_ff;
    assign carry_we_o       = c_we_ff;
    assign carry_o          = c_ff;
    assign soft_reset_req_o = rst_req_ff;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    logic take_ret;
    logic take_rot;
    assign take_ret = take && is_return(op_i);
    assign take_rot = take && !is_return(op_i) && op_i != RRRE_OP_SOFT_RESET;

    chk_ret_two_cycles: assert property (
        take_ret |=> stack_pop_o && !pc_load_o ##1 pc_load_o && done_o)
        else $error("return did not pop then load in two cycles");

    chk_ret_pc_value: assert property (
        take_ret |-> ##2 pc_value_o == $past(top_of_stack_i, 2))
        else $error("return loaded a PC other than the top of stack");

    chk_int_enable_set: assert property (
        take && op_i == RRRE_OP_RETURN_FROM_INTERRUPT
        |-> ##2 int_enable_set_o)
        else $error("interrupt return did not set the global enable");

    chk_int_enable_only: assert property (
        int_enable_set_o |-> pc_load_o && !carry_we_o && !w_we_o)
        else $error("global enable set outside an interrupt return");

    chk_literal_w_load: assert property (
        take && op_i == RRRE_OP_RETURN_WITH_LITERAL
        |-> ##2 w_we_o && w_data_o == $past(literal_i, 2) && pc_load_o)
        else $error("literal return did not load W and the PC");

    chk_ret_no_flags: assert property (
        busy_o || pc_load_o |-> !carry_we_o && !f_we_o)
        else $error("a return changed a flag or a file register");

    chk_rotr_result: assert property (
        take_rot && op_i == RRRE_OP_ROTATE_RIGHT_CARRY && !dest_i
        |=> w_we_o && w_data_o == {$past(carry_i), $past(f_rdata_i[7:1])}
            && carry_we_o && carry_o == $past(f_rdata_i[0]))
        else $error("rotate right result or carry wrong");

    chk_rotl_result: assert property (
        take_rot && op_i == RRRE_OP_ROTATE_LEFT_CARRY && dest_i
        |=> f_we_o && f_wdata_o == {$past(f_rdata_i[6:0]), $past(carry_i)}
            && carry_o == $past(f_rdata_i[7]) && done_o)
        else $error("rotate left result or carry wrong");

    chk_rot_dest: assert property (
        take_rot |=> f_we_o == $past(dest_i) && w_we_o == !$past(dest_i)
                     && (f_addr_o == $past(faddr_i) || !$past(dest_i)))
        else $error("rotate wrote the wrong destination");

    chk_soft_reset: assert property (
        take && op_i == RRRE_OP_SOFT_RESET |=> soft_reset_req_o [*3])
        else $error("software reset request not raised and held");

    cov_int_return: cover property (
        take && op_i == RRRE_OP_RETURN_FROM_INTERRUPT ##2 int_enable_set_o);
    cov_literal_return: cover property (
        take && op_i == RRRE_OP_RETURN_WITH_LITERAL ##2 w_we_o);
    cov_rotr_file: cover property (
        take_rot && op_i == RRRE_OP_ROTATE_RIGHT_CARRY && dest_i);
    cov_soft_reset: cover property (soft_reset_req_o);
endmodule

// ---- verif/test_return_rotate_reset_exec.sv ----
`timescale 1ns/1ns
module test_return_rotate_reset_exec;
    import rrre_pkg::*;

    logic                clk;
    logic                rstn;
    logic                op_valid_i;
    rrre_op_e            op_i;
    logic [DATA_W-1:0]   literal_i;
    logic [FADDR_W-1:0]  faddr_i;
    logic                dest_i;
    logic [DATA_W-1:0]   f_rdata_i;
    logic                carry_i;
    logic [PC_W-1:0]     top_of_stack_i;
    logic                busy_o;
    logic                done_o;
    logic                stack_pop_o;
    logic                pc_load_o;
    logic [PC_W-1:0]     pc_value_o;
    logic                int_enable_set_o;
    logic                w_we_o;
    logic [DATA_W-1:0]   w_data_o;
    logic                f_we_o;
    logic [FADDR_W-1:0]  f_addr_o;
    logic [DATA_W-1:0]   f_wdata_o;
    logic                carry_we_o;
    logic                carry_o;
    logic                soft_reset_req_o;
    int                  n_errors;
    int                  check_count;

    rrre_exec DUT (
        .clk(clk), .rstn(rstn), .op_valid_i(op_valid_i), .op_i(op_i),
        .literal_i(literal_i), .faddr_i(faddr_i), .dest_i(dest_i),
        .f_rdata_i(f_rdata_i), .carry_i(carry_i),
        .top_of_stack_i(top_of_stack_i), .busy_o(busy_o), .done_o(done_o),
        .stack_pop_o(stack_pop_o), .pc_load_o(pc_load_o),
        .pc_value_o(pc_value_o), .int_enable_set_o(int_enable_set_o),
        .w_we_o(w_we_o),
        .w_data_o(w_data_o), .f_we_o(f_we_o), .f_addr_o(f_addr_o),
        .f_wdata_o(f_wdata_o), .carry_we_o(carry_we_o), .carry_o(carry_o),
        .soft_reset_req_o(soft_reset_req_o)
    );

    always #25 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // The address and stack value are derived from the data and the literal,
    // so the task takes no separate arguments for them.
    task automatic go(input rrre_op_e op, input logic [7:0] k,
                      input logic d, input logic [7:0] fd, input logic c);
        op_valid_i = 1'b1;
        op_i = op;
        literal_i = k;
        dest_i = d;
        f_rdata_i = fd;
        carry_i = c;
        faddr_i = fd[6:0] ^ 7'h55;
        top_of_stack_i = {k[6:0], fd};
        @(posedge clk);
        #2;
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_rotates();
        logic [7:0] tab [4] = '{8'he6, 8'h81, 8'h01, 8'h7f};
        logic [7:0] res;
        logic       l;
        logic       d;
        logic       c;
        for (int i = 0; i < 4; i++) begin
            l = i[1];
            d = i[0];
            c = i[1] ^ i[0];
            res = l ? {tab[i][6:0], c} : {c, tab[i][7:1]};
            go(l ? RRRE_OP_ROTATE_LEFT_CARRY : RRRE_OP_ROTATE_RIGHT_CARRY,
               8'h00, d, tab[i], c);
            chk("done", done_o, 1);
            chk("carry_we", carry_we_o, 1);
            chk("carry", carry_o,
                l ? tab[i][7] : tab[i][0]);
            chk("w_we", w_we_o, !d);
            chk("f_we", f_we_o, d);
            chk("pop", stack_pop_o, 0);
            if (d) begin
                chk("f_wdata", f_wdata_o, res);
                chk("f_addr", f_addr_o, tab[i][6:0] ^ 7'h55);
            end else begin
                chk("w_data", w_data_o, res);
            end
        end
        op_valid_i = 1'b0;
        @(posedge clk);
        #2;
        chk("done idle", done_o, 0);
        $display("rotates done");
    endtask

    task automatic t_returns();
        rrre_op_e   ops [3] = '{RRRE_OP_RETURN_WITH_LITERAL,
                                RRRE_OP_RETURN_FROM_INTERRUPT, RRRE_OP_RETURN};
        logic [7:0] ks [3] = '{8'hff, 8'h00, 8'h5a};
        for (int i = 0; i < 3; i++) begin
            go(ops[i], ks[i], 1'b0, 8'h3c + 8'(i), 1'b1);
            chk("pop", stack_pop_o, 1);
            chk("busy", busy_o, 1);
            chk("pc_load early", pc_load_o, 0);
            op_valid_i = 1'b0;
            @(posedge clk);
            #2;
            chk("pc_load", pc_load_o, 1);
            chk("pc_value", pc_value_o,
                {ks[i][6:0], 8'h3c + 8'(i)});
            chk("done", done_o, 1);
            chk("busy off", busy_o, 0);
            chk("int_enable", int_enable_set_o, i == 1);
            chk("w_we", w_we_o, i == 0);
            chk("flags", carry_we_o, 0);
            chk("f_we", f_we_o, 0);
            if (i == 0)
                chk("w_data", w_data_o, ks[i]);
        end
        $display("returns done");
    endtask

    // A request held through the busy cycle must wait one edge more.
    task automatic t_busy();
        go(RRRE_OP_RETURN, 8'h12, 1'b0, 8'h34, 1'b0);
        op_i = RRRE_OP_ROTATE_RIGHT_CARRY;
        f_rdata_i = 8'h02;
        carry_i = 1'b1;
        @(posedge clk);
        #2;
        chk("pc_load", pc_load_o, 1);
        chk("early rotate", carry_we_o, 0);
        @(posedge clk);
        #2;
        op_valid_i = 1'b0;
        chk("late rotate", carry_we_o, 1);
        chk("w_data", w_data_o, 8'h81);
        chk("carry", carry_o, 0);
        @(posedge clk);
        #2;
        chk("rotate once", carry_we_o, 0);
        $display("busy done");
    endtask

    task automatic t_soft();
        go(RRRE_OP_SOFT_RESET, 8'h00, 1'b0, 8'h00, 1'b0);
        chk("soft req", soft_reset_req_o, 1);
        chk("done", done_o, 1);
        go(RRRE_OP_ROTATE_LEFT_CARRY, 8'h00, 1'b0, 8'h80, 1'b0);
        op_valid_i = 1'b0;
        chk("after soft", carry_we_o, 0);
        chk("soft held", soft_reset_req_o, 1);
        rstn = 1'b0;
        #5;
        chk("soft cleared", soft_reset_req_o, 0);
        @(posedge clk);
        #2;
        rstn = 1'b1;
        $display("soft reset done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #(5000 * 50);
        n_errors++;
        stop_test();
    end

    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        op_valid_i = 1'b0;
        op_i = RRRE_OP_RETURN;
        literal_i = 8'h00;
        faddr_i = 7'h00;
        dest_i = 1'b0;
        f_rdata_i = 8'h00;
        carry_i = 1'b0;
        top_of_stack_i = 15'h0000;
        repeat (20) @(posedge clk);
        #2;
        chk("reset busy", busy_o, 0);
        chk("reset soft", soft_reset_req_o, 0);
        rstn = 1'b1;
        t_rotates();
        t_returns();
        t_busy();
        t_soft();
        stop_test();
    end
endmodule
